/* rtl/asbr_pkg.sv */
// constants shared by the serial bit recovery block and its transmit buffer
// assumes one clock mclk and a synchronous active-high reset
package asbr_pkg;
  localparam int DIV_W       = 16;       // width of the oversampling divider
  localparam int DATA_W      = 8;        // character width
  localparam int FIFO_DEPTH  = 32;       // transmit buffer depth in words
  localparam int RT_W        = 5;        // oversampling tick counter width
  localparam int BIT_W       = 4;        // data bit index width
  localparam int TX_FRAME_W  = 10;       // start + data + stop
  localparam logic [DIV_W-1:0] DIV_ZERO  = 16'h0000;
  localparam logic [RT_W-1:0]  RT_ONE    = 5'h01;
  localparam logic [RT_W-1:0]  RT_TWO    = 5'h02;   // first tick after the start edge
  localparam logic [RT_W-1:0]  RT_THREE  = 5'h03;
  localparam logic [RT_W-1:0]  RT_FIVE   = 5'h05;
  localparam logic [RT_W-1:0]  RT_EIGHT  = 5'h08;
  localparam logic [RT_W-1:0]  RT_NINE   = 5'h09;
  localparam logic [RT_W-1:0]  RT_TEN    = 5'h0A;
  localparam logic [RT_W-1:0]  RT_LAST   = 5'h10;   // sixteen ticks per bit
  localparam logic [BIT_W-1:0] BIT_LAST  = 4'h7;    // last data bit index
  localparam logic [BIT_W-1:0] TX_LAST   = 4'h9;    // last transmitted frame bit
  typedef enum logic [1:0] {ASBR_IDLE, ASBR_START, ASBR_DATA, ASBR_STOP} asbr_rx_state_type;
endpackage

/* rtl/asbr_fifo.sv */
// first-in first-out buffer, width and depth set by parameters
// assumes one clock and a synchronous active-high reset; depth a power of two
module asbr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic [PW:0]      next_wr_ptr;
  logic [PW:0]      next_rd_ptr;
  logic             full;
  logic             empty;

  // extra pointer bit tells full from empty
  assign full      = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[PW-1:0]];

  // pointer advance on each accepted handshake
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (in_valid && !full) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (out_ready && !empty) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage has no reset, only written words are ever read
  always_ff @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end
endmodule // asbr_fifo

/* rtl/asbr_serial.sv */
// asynchronous serial unit: receive bit recovery with noise and framing flags,
// plus a buffered transmitter; assumes rx_line is already synchronous to mclk
module asbr_serial (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic [asbr_pkg::DIV_W-1:0] baud_div,
  input  wire logic                       rx_enable,
  input  wire logic                       tx_enable,
  input  wire logic                       rx_line,
  output logic                            tx_line_out,
  output logic                            tx_line_oe,
  output logic [asbr_pkg::DATA_W-1:0]     rx_data,
  output logic                            rx_valid,
  output logic                            noise_flag,
  output logic                            framing_error_flag,
  input  wire logic                       noise_clear,
  input  wire logic                       framing_clear,
  input  wire logic [asbr_pkg::DATA_W-1:0] tx_data,
  input  wire logic                       tx_valid,
  output logic                            tx_ready,
  output logic                            tx_busy
);
  logic [asbr_pkg::DIV_W-1:0]      div_cnt, next_div_cnt;
  asbr_pkg::asbr_rx_state_type     rx_state, next_rx_state;
  logic [asbr_pkg::RT_W-1:0]       rt, next_rt, tx_rt, next_tx_rt;
  logic [2:0]                      samp, next_samp, stop_samp;
  logic [asbr_pkg::BIT_W-1:0]      bit_idx, next_bit_idx, tx_bit, next_tx_bit;
  logic [asbr_pkg::DATA_W-1:0]     shreg, next_shreg, next_rx_data, buf_data;
  logic [asbr_pkg::TX_FRAME_W-1:0] tx_sh, next_tx_sh;
  logic                            tick, maj, unanimous, fall_edge, reject;
  logic                            last_level, next_last_level, next_rx_valid;
  logic                            set_noise, set_framing, next_noise_flag, next_framing_flag;
  logic                            tx_active, next_tx_active, buf_valid, buf_take;

  // oversampling tick divider: one pulse every baud_div+1 clocks
  always_comb begin
    next_div_cnt = div_cnt - 1'b1;
    tick         = (div_cnt == asbr_pkg::DIV_ZERO);
    if (tick) begin
      next_div_cnt = baud_div;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_cnt <= asbr_pkg::DIV_ZERO;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // majority vote of the three mid-bit samples
  assign stop_samp = {samp[1:0], rx_line};                  // ticks eight, nine held, ten live
  assign maj       = (samp[2] & samp[1]) | (samp[2] & samp[0]) | (samp[1] & samp[0]);
  assign unanimous = (samp == 3'h0) || (samp == 3'h7);
  assign fall_edge = last_level && !rx_line;
  assign reject    = ((rt == asbr_pkg::RT_THREE) || (rt == asbr_pkg::RT_FIVE)) && rx_line;

  // receive recovery: verification, sampling, assembly of characters
  always_comb begin
    next_rx_state   = rx_state;
    next_rt         = rt;
    next_samp       = samp;
    next_bit_idx    = bit_idx;
    next_shreg      = shreg;
    next_last_level = last_level;
    next_rx_valid   = 1'b0;
    next_rx_data    = rx_data;
    set_noise       = 1'b0;
    set_framing     = 1'b0;
    if (!rx_enable) begin
      // line ignored; a high must be seen again before a start is searched
      next_rx_state   = asbr_pkg::ASBR_IDLE;
      next_last_level = 1'b0;
    end else if (tick) begin
      next_rt = (rt == asbr_pkg::RT_LAST) ? asbr_pkg::RT_ONE : rt + 1'b1;
      if (rt == asbr_pkg::RT_EIGHT || rt == asbr_pkg::RT_NINE || rt == asbr_pkg::RT_TEN) begin
        next_samp = {samp[1:0], rx_line};
      end
      case (rx_state)
        asbr_pkg::ASBR_IDLE: begin
          next_last_level = rx_line;
          if (fall_edge) begin
            next_rx_state = asbr_pkg::ASBR_START;
            next_rt       = asbr_pkg::RT_TWO;                // edge tick was tick one
          end
        end
        asbr_pkg::ASBR_START: begin
          if (reject) begin
            // noise before verification: no flag, search again
            next_rx_state   = asbr_pkg::ASBR_IDLE;
            next_last_level = 1'b1;
          end else if (rt == asbr_pkg::RT_LAST) begin
            // mid samples only judged after verification, bit taken as zero
            set_noise     = (samp != 3'h0);
            next_rx_state = asbr_pkg::ASBR_DATA;
            next_bit_idx  = '0;
          end
        end
        asbr_pkg::ASBR_DATA: begin
          if (rt == asbr_pkg::RT_LAST) begin
            next_shreg = {maj, shreg[asbr_pkg::DATA_W-1:1]};
            set_noise  = !unanimous;
            next_bit_idx = bit_idx + 1'b1;
            if (bit_idx == asbr_pkg::BIT_LAST) begin
              next_rx_state = asbr_pkg::ASBR_STOP;
            end
          end
        end
        asbr_pkg::ASBR_STOP: begin
          if (rt == asbr_pkg::RT_TEN) begin
            // early finish at tick ten so a following start edge is not missed
            set_framing     = ((stop_samp[2] & stop_samp[1]) | (stop_samp[2] & stop_samp[0])
                              | (stop_samp[1] & stop_samp[0])) == 1'b0;
            set_noise       = (stop_samp != 3'h0) && (stop_samp != 3'h7);
            next_rx_valid   = 1'b1;
            next_rx_data    = shreg;
            next_rx_state   = asbr_pkg::ASBR_IDLE;
            next_last_level = 1'b1;
          end
        end
        default: begin
          next_rx_state = asbr_pkg::ASBR_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_state   <= asbr_pkg::ASBR_IDLE;
      rt         <= asbr_pkg::RT_ONE;
      samp       <= 3'h0;
      bit_idx    <= '0;
      shreg      <= '0;
      last_level <= 1'b0;
      rx_valid   <= 1'b0;
      rx_data    <= '0;
    end else begin
      rx_state   <= next_rx_state;
      rt         <= next_rt;
      samp       <= next_samp;
      bit_idx    <= next_bit_idx;
      shreg      <= next_shreg;
      last_level <= next_last_level;
      rx_valid   <= next_rx_valid;
      rx_data    <= next_rx_data;
    end
  end

  // sticky flags: a set in the clear cycle wins
  always_comb begin
    next_noise_flag   = (noise_flag && !noise_clear) || set_noise;
    next_framing_flag = (framing_error_flag && !framing_clear) || set_framing;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      noise_flag         <= 1'b0;
      framing_error_flag <= 1'b0;
    end else begin
      noise_flag         <= next_noise_flag;
      framing_error_flag <= next_framing_flag;
    end
  end

  // transmit buffer; the shifter pulls only when idle, so writers stall when full
  asbr_fifo #(
    .WIDTH (asbr_pkg::DATA_W),
    .DEPTH (asbr_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_take)
  );

  assign buf_take    = tx_enable && !tx_active;
  assign tx_busy     = tx_active;
  assign tx_line_out = tx_active ? tx_sh[0] : 1'b1;
  assign tx_line_oe  = tx_enable;

  // transmit shifter, sixteen ticks per bit; disabling aborts the frame
  always_comb begin
    next_tx_active = tx_active;
    next_tx_sh     = tx_sh;
    next_tx_bit    = tx_bit;
    next_tx_rt     = tx_rt;
    if (!tx_enable) begin
      next_tx_active = 1'b0;
    end else if (!tx_active) begin
      if (buf_valid) begin
        next_tx_active = 1'b1;
        next_tx_sh     = {1'b1, buf_data, 1'b0};
        next_tx_bit    = '0;
        next_tx_rt     = asbr_pkg::RT_ONE;
      end
    end else if (tick) begin
      next_tx_rt = tx_rt + 1'b1;
      if (tx_rt == asbr_pkg::RT_LAST) begin
        next_tx_rt  = asbr_pkg::RT_ONE;
        next_tx_sh  = {1'b1, tx_sh[asbr_pkg::TX_FRAME_W-1:1]};
        next_tx_bit = tx_bit + 1'b1;
        if (tx_bit == asbr_pkg::TX_LAST) begin
          next_tx_active = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_active <= 1'b0;
      tx_sh     <= '1;
      tx_bit    <= '0;
      tx_rt     <= asbr_pkg::RT_ONE;
    end else begin
      tx_active <= next_tx_active;
      tx_sh     <= next_tx_sh;
      tx_bit    <= next_tx_bit;
      tx_rt     <= next_tx_rt;
    end
  end

  // checks next to the logic they guard
  sequence s_start_seen;
    rx_enable && tick && rx_state == asbr_pkg::ASBR_IDLE && fall_edge;
  endsequence
  sequence s_rejected;
    rx_enable && tick && rx_state == asbr_pkg::ASBR_START && reject;
  endsequence
  property p_tx_idle_high;
    @(posedge mclk) disable iff (rst) (tx_enable && !tx_active) |-> tx_line_out;
  endproperty
  a_tx_idle_high: assert property (p_tx_idle_high) else $error("tx not high when idle");
  property p_tx_off_released;
    @(posedge mclk) disable iff (rst) !tx_enable |=> !tx_active && !tx_line_oe || tx_enable;
  endproperty
  a_tx_off_released: assert property (p_tx_off_released) else $error("tx driven while off");
  property p_idle_high_stays;
    @(posedge mclk) disable iff (rst)
      (rx_state == asbr_pkg::ASBR_IDLE && rx_line && $past(rx_line)) |=>
      rx_state == asbr_pkg::ASBR_IDLE;
  endproperty
  a_idle_high_stays: assert property (p_idle_high_stays) else $error("idle line left idle");
  property p_rx_off_quiet;
    @(posedge mclk) disable iff (rst)
      !rx_enable |=> !rx_valid && (noise_flag == 1'b0 || $past(noise_flag));
  endproperty
  a_rx_off_quiet: assert property (p_rx_off_quiet) else $error("receive activity while off");
  property p_data_majority;
    @(posedge mclk) disable iff (rst)
      (rx_enable && tick && rx_state == asbr_pkg::ASBR_DATA && rt == asbr_pkg::RT_LAST)
      |=> shreg[asbr_pkg::DATA_W-1] == $past(maj) && (noise_flag || $past(unanimous));
  endproperty
  a_data_majority: assert property (p_data_majority) else $error("data bit vote wrong");
  property p_start_noise;
    @(posedge mclk) disable iff (rst)
      (rx_enable && tick && rx_state == asbr_pkg::ASBR_START && rt == asbr_pkg::RT_LAST
       && samp != 3'h0) |=> noise_flag && rx_state == asbr_pkg::ASBR_DATA;
  endproperty
  a_start_noise: assert property (p_start_noise) else $error("start noise not flagged");
  property p_stop_framing;
    @(posedge mclk) disable iff (rst)
      (rx_enable && tick && rx_state == asbr_pkg::ASBR_STOP && rt == asbr_pkg::RT_TEN
       && stop_samp inside {3'h0, 3'h1, 3'h2, 3'h4}) |=> framing_error_flag && rx_valid;
  endproperty
  a_stop_framing: assert property (p_stop_framing) else $error("framing error missed");
  property p_reject_restart;
    @(posedge mclk) disable iff (rst)
      s_rejected |=> rx_state == asbr_pkg::ASBR_IDLE && (noise_flag == $past(noise_flag)
      || $past(noise_clear));
  endproperty
  a_reject_restart: assert property (p_reject_restart) else $error("noise start not dropped");
  property p_tick_align;
    @(posedge mclk) disable iff (rst)
      s_start_seen |=> rx_state == asbr_pkg::ASBR_START && rt == asbr_pkg::RT_TWO;
  endproperty
  a_tick_align: assert property (p_tick_align) else $error("tick one not on edge");
endmodule // asbr_serial

/* testbench/asbr_remote.sv */
// remote serial partner: sends framed characters to the receiver, decodes the transmitter
// assumes the design divider ticks on the first edge after reset, then every baud_div+1 clocks
module asbr_remote (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic [asbr_pkg::DIV_W-1:0] baud_div,
  input  wire logic                       go,
  input  wire logic [7:0]                 data,
  input  wire logic [3:0]                 glitch_bit,
  input  wire logic [2:0]                 glitch_mask,
  input  wire logic [1:0]                 false_mode,
  input  wire logic                       tx_wire,
  output logic                            busy,
  output logic                            rx_line,
  output logic [7:0]                      tx_byte,
  output logic                            tx_got
);
  timeunit 1ns;
  timeprecision 1ps;
  int         div_cnt;
  int         pos;
  int         p;
  int         tcnt;
  int         bt;
  logic       lvl;
  logic       tx_prev;
  logic [9:0] frame;
  logic [9:0] tsh;

  // frame generator on the receiver's tick edges; each edge sets the level for the next tick
  always @(posedge mclk) begin
    if (rst) begin
      div_cnt <= 0;
      pos     <= 0;
      busy    <= 1'b0;
      rx_line <= 1'b1;
    end else begin
      div_cnt <= (div_cnt == int'(baud_div)) ? 0 : div_cnt + 1;
      if (go) begin
        busy <= 1'b1;
      end
      if (div_cnt == 0 && busy) begin
        p     = pos + 1;
        frame = {1'b1, data, 1'b0};
        lvl   = (p <= 160) ? frame[(p - 1) / 16] : 1'b1;
        // flip chosen mid-bit samples only, the rest of the bit stays clean
        if ((p - 1) / 16 == int'(glitch_bit) && (p - 1) % 16 >= 7 && (p - 1) % 16 <= 9) begin
          lvl = lvl ^ glitch_mask[9 - (p - 1) % 16];
        end
        if (false_mode != 2'b00 && p >= ((false_mode == 2'b01) ? 3 : 5)) begin
          lvl = 1'b1;
        end
        rx_line <= lvl;
        pos     <= p;
        if (p == 161 || (false_mode != 2'b00 && p == 17)) begin
          busy <= 1'b0;
          pos  <= 0;
        end
      end
    end
  end

  // mid-bit decoder; a released line reads as the pull-up level, so no false start
  always @(posedge mclk) begin
    bt = 16 * (int'(baud_div) + 1);
    tx_got  <= 1'b0;
    tx_prev <= tx_wire;
    if (rst) begin
      tcnt <= -1;
    end else if (tcnt < 0) begin
      if (tx_prev && !tx_wire) begin
        tcnt <= 0;
      end
    end else begin
      tcnt <= tcnt + 1;
      if (tcnt % bt == bt / 2) begin
        tsh[tcnt / bt] <= tx_wire;
      end
      if (tcnt == 9 * bt + bt / 2 + 1) begin
        tx_byte <= tsh[8:1];
        tx_got  <= tsh[9] & ~tsh[0];  // bad framing shows up as a lost character
        tcnt    <= -1;
      end
    end
  end
endmodule  // asbr_remote

/* testbench/async_serial_bit_recovery_bench.sv */
// self-checking bench for the serial bit recovery block and its transmit buffer
// assumes the package and the remote partner model are compiled first
module async_serial_bit_recovery_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [asbr_pkg::DIV_W-1:0] BAUD = 16'h0001;  // short bit time of 32 clocks
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       rx_enable = 1'b1;
  logic       tx_enable = 1'b1;
  logic       noise_clear = 1'b0;
  logic       framing_clear = 1'b0;
  logic       tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h40;
  logic       go = 1'b0;
  logic [7:0] data = 8'h00;
  logic [3:0] glitch_bit = 4'hF;
  logic [2:0] glitch_mask = 3'h0;
  logic [1:0] false_mode = 2'h0;
  logic       rx_line, tx_line_out, tx_line_oe, rx_valid, noise_flag, framing_error_flag;
  logic       tx_ready, tx_busy, busy, tx_got, tx_wire;
  logic [7:0] rx_data, tx_byte;
  logic [7:0] tx_q[$];
  int         num_errors = 0;
  int         num_checks = 0;
  int         rx_count = 0;
  int         wr_count = 0;

  assign tx_wire = tx_line_oe ? tx_line_out : 1'b1;  // pull-up while released

  asbr_serial u_asbr_serial (.mclk(mclk), .rst(rst), .baud_div(BAUD), .rx_enable(rx_enable),
    .tx_enable(tx_enable), .rx_line(rx_line), .tx_line_out(tx_line_out),
    .tx_line_oe(tx_line_oe), .rx_data(rx_data), .rx_valid(rx_valid), .noise_flag(noise_flag),
    .framing_error_flag(framing_error_flag), .noise_clear(noise_clear),
    .framing_clear(framing_clear), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_busy(tx_busy));

  asbr_remote u_asbr_remote (.mclk(mclk), .rst(rst), .baud_div(BAUD), .go(go), .data(data),
    .glitch_bit(glitch_bit), .glitch_mask(glitch_mask), .false_mode(false_mode),
    .tx_wire(tx_wire), .busy(busy), .rx_line(rx_line), .tx_byte(tx_byte), .tx_got(tx_got));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic maj(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // one character from the partner, then wait for it to finish under a bound
  task automatic send(input logic [7:0] d, input logic [3:0] gb, input logic [2:0] gm,
                      input logic [1:0] fm);
    int n;
    @(posedge mclk);
    data        <= d;
    glitch_bit  <= gb;
    glitch_mask <= gm;
    false_mode  <= fm;
    go          <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    for (n = 0; n < 2000; n++) begin
      @(negedge mclk);
      if (busy === 1'b0) break;
    end
    if (n == 2000) begin
      num_errors++;
      print_verdict();
    end
    repeat (3) @(negedge mclk);
  endtask

  task automatic clear_flags();
    @(posedge mclk);
    noise_clear   <= 1'b1;
    framing_clear <= 1'b1;
    @(posedge mclk);
    noise_clear   <= 1'b0;
    framing_clear <= 1'b0;
  endtask

  initial begin
    forever #2 mclk = ~mclk;
  end

  // counts receive pulses and accepted writes; the write data steps only on acceptance
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) rx_count <= rx_count + 1;
    if (tx_valid && tx_ready) begin
      wr_count <= wr_count + 1;
      tx_data  <= tx_data + 8'h01;
    end
    if (tx_got) tx_q.push_back(tx_byte);
  end

  initial begin
    int gb, i, m, n, c;
    logic [7:0] exp_d;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check("tx_line_out", 8'h01, tx_line_out);
    check("tx_line_oe", 8'h01, tx_line_oe);
    check("tx_ready", 8'h01, tx_ready);
    send(8'h1E, 4'hF, 3'h0, 2'h0);
    check("rx_count", 8'h01, 8'(rx_count));
    check("rx_data", 8'h1E, rx_data);
    // every sample pattern on the start bit, one data bit and the stop bit
    for (i = 0; i < 3; i++) begin
      gb = (i == 0) ? 0 : (i == 1) ? 2 : 9;
      for (m = 0; m < 8; m++) begin
        c = rx_count;
        send(8'h1E, 4'(gb), 3'(m), 2'h0);
        exp_d = 8'h1E;
        if (gb == 2) exp_d[1] = maj(~3'(m));
        check("rx_count", 8'(c + 1), 8'(rx_count));
        check("rx_data", exp_d, rx_data);
        check("noise", (gb == 0) ? 8'(m != 0) : 8'(m != 0 && m != 7), noise_flag);
        check("framing", (gb == 9) ? 8'(!maj(~3'(m))) : 8'h00, framing_error_flag);
        clear_flags();
      end
    end
    // rejected starts, each followed at once by a good character
    for (m = 1; m < 3; m++) begin
      c = rx_count;
      send(8'h00, 4'hF, 3'h0, 2'(m));
      check("rx_count", 8'(c), 8'(rx_count));
      check("noise_flag", 8'h00, noise_flag);
      send(8'hC3, 4'hF, 3'h0, 2'h0);
      check("rx_data", 8'hC3, rx_data);
    end
    // a noisy character while the receiver is off must leave no trace
    @(posedge mclk);
    rx_enable <= 1'b0;
    c = rx_count;
    send(8'h99, 4'h2, 3'h3, 2'h0);
    check("rx_count", 8'(c), 8'(rx_count));
    check("rx_data", 8'hC3, rx_data);
    check("noise_flag", 8'h00, noise_flag);
    @(posedge mclk);
    rx_enable <= 1'b1;
    send(8'h5A, 4'hF, 3'h0, 2'h0);
    check("rx_data", 8'h5A, rx_data);
    // fill the buffer with the transmitter off, then drain it through the line
    @(posedge mclk);
    tx_enable <= 1'b0;
    tx_valid  <= 1'b1;
    repeat (40) @(posedge mclk);
    tx_valid <= 1'b0;
    @(negedge mclk);
    check("tx_line_oe", 8'h00, tx_line_oe);
    check("wr_count", 8'(asbr_pkg::FIFO_DEPTH), 8'(wr_count));
    check("tx_ready", 8'h00, tx_ready);
    @(posedge mclk);
    tx_enable <= 1'b1;
    for (n = 0; n < 12000 && tx_q.size() < 32; n++) @(negedge mclk);
    check("tx_count", 8'h20, 8'(tx_q.size()));
    for (n = 0; n < 32 && n < tx_q.size(); n++) check("tx_byte", 8'h40 + 8'(n), tx_q[n]);
    repeat (40) @(negedge mclk);
    check("tx_line_out", 8'h01, tx_line_out);
    check("tx_busy", 8'h00, tx_busy);
    print_verdict();
  end
endmodule  // async_serial_bit_recovery_bench
